// ---- src/fpwm_cfg.svh ----
// offsets, field positions, reset values and timing figures of the fan pwm block
`ifndef FPWM_CFG_SVH
`define FPWM_CFG_SVH

// register byte offsets on the avalon slave
`define FPWM_OFS_PRESCALE     4'h0
`define FPWM_OFS_DUTY         4'h4
`define FPWM_OFS_CTRL         4'h8
`define FPWM_OFS_STATUS       4'hC

// prescale register fields
`define FPWM_PSC_SEL_BIT      7
`define FPWM_PSC_DIV_MSB      6
`define FPWM_PSC_MAX_DIV      7'h7B

// control register fields
`define FPWM_CTRL_EN_BIT      0
`define FPWM_CTRL_INV_BIT     1
`define FPWM_CTRL_OTF_BIT     2

// status register fields
`define FPWM_STS_PWM_BIT      8
`define FPWM_STS_OT_BIT       9
`define FPWM_STS_FORCE_BIT    10

// reset values
`define FPWM_RST_PRESCALE     8'h00
`define FPWM_RST_DUTY         8'hFF
`define FPWM_RST_CTRL         3'h0

// counter figures
`define FPWM_CNT_LAST         8'hFF
`define FPWM_DUTY_FULL        8'hFF

// clock rates in kHz: system clock and the two divider sources
`define FPWM_SYS_KHZ          250000
`define FPWM_SRC_FAST_KHZ     24000
`define FPWM_SRC_SLOW_KHZ     200

`endif

// ---- src/fpwm_pkg.sv ----
// types shared by the fan pwm block
package fpwm_pkg;

    // bus slave handshake states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h1,
        BUS_ACK  = 2'h2
    } fpwm_bus_t;

    // decoded register select
    typedef enum logic [4:0] {
        SEL_NONE     = 5'h01,
        SEL_PRESCALE = 5'h02,
        SEL_DUTY     = 5'h04,
        SEL_CTRL     = 5'h08,
        SEL_STATUS   = 5'h10
    } fpwm_sel_t;

endpackage

// ---- src/fpwm_tick_gen.sv ----
// fractional rate generator: one-cycle enable pulses at an average source rate
`timescale 1ns/100ps
`default_nettype none

module fpwm_tick_gen #(
    parameter int unsigned ACC_W   = 18,
    parameter int unsigned STEP    = 24000,
    parameter int unsigned MODULUS = 250000
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // enable pulse
    output logic      tick
);

    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] acc_next;
    logic             tick_reg;
    logic             tick_next;
    logic [ACC_W:0]   sum;

    // phase accumulator: jitter of one system clock traded for exact mean rate
    always_comb begin
        sum       = {1'b0, acc_reg} + ACC_W'(STEP);
        acc_next  = sum[ACC_W-1:0];
        tick_next = 1'b0;
        if (sum >= (ACC_W+1)'(MODULUS)) begin
            acc_next  = ACC_W'(sum - (ACC_W+1)'(MODULUS));
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            acc_reg  <= acc_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule

`default_nettype wire

// ---- src/fpwm_top.sv ----
// fan pwm speed control: avalon register slave, prescaler, pwm counter, fan output
//
// Overview of operation
// - 8-bit counter wraps every 256 counter ticks
// - output high while count below duty
// - duty zero low unless forced, FFh high while enabled
// - invert bit complements the fan output
// - prescale bit 7 picks 24 MHz/200 kHz
// - selected source divided by field plus one
// - field zero passes source undivided
// - overtemperature with force bit set forces full duty
// - prescale register resets to zero
// - duty register resets to all ones
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "fpwm_cfg.svh"

module fpwm_top #(
    parameter int unsigned OT_CH = 2
) (
    // clock and reset
    input  wire logic             REF_CLK,
    input  wire logic             RESETN,
    // avalon-mm slave
    input  wire logic [3:0]       AVS_ADDRESS,
    input  wire logic             AVS_READ,
    input  wire logic             AVS_WRITE,
    input  wire logic [31:0]      AVS_WRITEDATA,
    input  wire logic [3:0]       AVS_BYTEENABLE,
    output logic      [31:0]      AVS_READDATA,
    output logic                  AVS_WAITREQUEST,
    // temperature channel flags, asynchronous
    input  wire logic [OT_CH-1:0] OVERTEMP_SHUTDOWN,
    // fan drive
    output logic                  FAN_DRIVE_OUT
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode, shared by read and write paths

    function automatic fpwm_pkg::fpwm_sel_t fpwm_decode(input logic [3:0] addr);
        fpwm_pkg::fpwm_sel_t s;
        case (addr)
            `FPWM_OFS_PRESCALE: s = fpwm_pkg::SEL_PRESCALE;
            `FPWM_OFS_DUTY:     s = fpwm_pkg::SEL_DUTY;
            `FPWM_OFS_CTRL:     s = fpwm_pkg::SEL_CTRL;
            `FPWM_OFS_STATUS:   s = fpwm_pkg::SEL_STATUS;
            default:            s = fpwm_pkg::SEL_NONE;
        endcase
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // source rate enables

    logic tick_fast;
    logic tick_slow;

    fpwm_tick_gen #(
        .ACC_W   (18),
        .STEP    (`FPWM_SRC_FAST_KHZ),
        .MODULUS (`FPWM_SYS_KHZ)
    ) u_tick_fast (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .tick  (tick_fast)
    );

    fpwm_tick_gen #(
        .ACC_W   (18),
        .STEP    (`FPWM_SRC_SLOW_KHZ),
        .MODULUS (`FPWM_SYS_KHZ)
    ) u_tick_slow (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .tick  (tick_slow)
    );

    ////////////////////////////////////////////////////////////////////////////
    // overtemperature synchroniser

    logic [OT_CH-1:0] ot_meta_reg;
    logic [OT_CH-1:0] ot_sync_reg;

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ot_meta_reg <= '0;
            ot_sync_reg <= '0;
        end else begin
            ot_meta_reg <= OVERTEMP_SHUTDOWN;
            ot_sync_reg <= ot_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file and bus slave

    fpwm_pkg::fpwm_bus_t bus_reg;
    fpwm_pkg::fpwm_bus_t bus_next;
    fpwm_pkg::fpwm_sel_t sel;
    logic [7:0]          prescale_reg;
    logic [7:0]          prescale_next;
    logic [7:0]          duty_reg;
    logic [7:0]          duty_next;
    logic [2:0]          ctrl_reg;
    logic [2:0]          ctrl_next;
    logic [31:0]         rdata_reg;
    logic [31:0]         rdata_next;
    logic                wait_reg;
    logic                wait_next;
    logic                req;
    logic                wr_now;
    logic [7:0]          count_reg;
    logic                pwm_reg;
    logic                force_on;
    logic                ot_any;

    assign req    = AVS_READ | AVS_WRITE;
    assign sel    = fpwm_decode(AVS_ADDRESS);
    assign wr_now = AVS_WRITE && !wait_reg && bus_reg == fpwm_pkg::BUS_ACK;
    assign ot_any = |ot_sync_reg;

    // one wait cycle per access; write lands on the edge that sees waitrequest low
    always_comb begin
        bus_next      = bus_reg;
        wait_next     = 1'b1;
        rdata_next    = rdata_reg;
        prescale_next = prescale_reg;
        duty_next     = duty_reg;
        ctrl_next     = ctrl_reg;
        case (bus_reg)
            fpwm_pkg::BUS_IDLE: begin
                if (req) begin
                    bus_next   = fpwm_pkg::BUS_ACK;
                    wait_next  = 1'b0;
                    rdata_next = 32'h0000_0000;
                    if (AVS_READ) begin
                        case (sel)
                            fpwm_pkg::SEL_PRESCALE: rdata_next[7:0] = prescale_reg;
                            fpwm_pkg::SEL_DUTY:     rdata_next[7:0] = duty_reg;
                            fpwm_pkg::SEL_CTRL:     rdata_next[2:0] = ctrl_reg;
                            fpwm_pkg::SEL_STATUS: begin
                                rdata_next[7:0]                  = count_reg;
                                rdata_next[`FPWM_STS_PWM_BIT]    = pwm_reg;
                                rdata_next[`FPWM_STS_OT_BIT]     = ot_any;
                                rdata_next[`FPWM_STS_FORCE_BIT]  = force_on;
                            end
                            default: rdata_next = 32'h0000_0000;
                        endcase
                    end
                end
            end
            fpwm_pkg::BUS_ACK: begin
                bus_next = fpwm_pkg::BUS_IDLE;
                // unmapped offsets and the status word ignore writes
                if (wr_now && AVS_BYTEENABLE[0]) begin
                    case (sel)
                        fpwm_pkg::SEL_PRESCALE: prescale_next = AVS_WRITEDATA[7:0];
                        fpwm_pkg::SEL_DUTY:     duty_next     = AVS_WRITEDATA[7:0];
                        fpwm_pkg::SEL_CTRL:     ctrl_next     = AVS_WRITEDATA[2:0];
                        default:                ctrl_next     = ctrl_reg;
                    endcase
                end
            end
            default: begin
                bus_next = fpwm_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bus_reg      <= fpwm_pkg::BUS_IDLE;
            wait_reg     <= 1'b1;
            rdata_reg    <= 32'h0000_0000;
            prescale_reg <= `FPWM_RST_PRESCALE;
            duty_reg     <= `FPWM_RST_DUTY;
            ctrl_reg     <= `FPWM_RST_CTRL;
        end else begin
            bus_reg      <= bus_next;
            wait_reg     <= wait_next;
            rdata_reg    <= rdata_next;
            prescale_reg <= prescale_next;
            duty_reg     <= duty_next;
            ctrl_reg     <= ctrl_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // prescaler, pwm counter and output

    logic       enable;
    logic       invert;
    logic       src_tick;
    logic       cnt_tick;
    logic [6:0] div_reg;
    logic [6:0] div_next;
    logic [7:0] count_next;
    logic [7:0] duty_act_reg;
    logic [7:0] duty_act_next;
    logic       pwm_next;
    logic       out_reg;
    logic       out_next;

    assign enable   = ctrl_reg[`FPWM_CTRL_EN_BIT];
    assign invert   = ctrl_reg[`FPWM_CTRL_INV_BIT];
    assign force_on = ctrl_reg[`FPWM_CTRL_OTF_BIT] && ot_any;
    // field values 7Ch..7Fh are never written, so no guard against them
    assign src_tick = prescale_reg[`FPWM_PSC_SEL_BIT] ? tick_slow : tick_fast;
    assign cnt_tick = enable && src_tick && div_reg == prescale_reg[`FPWM_PSC_DIV_MSB:0];

    always_comb begin
        div_next      = div_reg;
        count_next    = count_reg;
        duty_act_next = duty_act_reg;
        if (!enable) begin
            div_next      = 7'h00;
            count_next    = 8'h00;
            duty_act_next = duty_reg;
        end else if (src_tick) begin
            div_next = cnt_tick ? 7'h00 : 7'(div_reg + 7'h01);
            if (cnt_tick) begin
                count_next = 8'(count_reg + 8'h01);
                // duty only reloads at the wrap, so no runt pulse
                if (count_reg == `FPWM_CNT_LAST) begin
                    duty_act_next = duty_reg;
                end
            end
        end
        // full scale stays high through the last count
        if (force_on) begin
            pwm_next = 1'b1;
        end else if (!enable) begin
            pwm_next = 1'b0;
        end else if (duty_act_reg == `FPWM_DUTY_FULL) begin
            pwm_next = 1'b1;
        end else begin
            pwm_next = count_reg < duty_act_reg;
        end
        out_next = pwm_next ^ invert;
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            div_reg      <= 7'h00;
            count_reg    <= 8'h00;
            duty_act_reg <= `FPWM_RST_DUTY;
            pwm_reg      <= 1'b0;
            out_reg      <= 1'b0;
        end else begin
            div_reg      <= div_next;
            count_reg    <= count_next;
            duty_act_reg <= duty_act_next;
            pwm_reg      <= pwm_next;
            out_reg      <= out_next;
        end
    end

    assign AVS_READDATA    = rdata_reg;
    assign AVS_WAITREQUEST = wait_reg;
    assign FAN_DRIVE_OUT   = out_reg;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    logic first_reg;

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    a_count_wrap: assert property (cnt_tick && count_reg == 8'hFF |=> count_reg == 8'h00)
        else $error("counter did not wrap to zero");
    a_count_step: assert property (cnt_tick && count_reg != 8'hFF
                                   |=> count_reg == $past(count_reg) + 8'h01)
        else $error("counter did not step by one");
    a_pwm_below: assert property (enable && !force_on && count_reg < duty_act_reg
                                  |=> pwm_reg)
        else $error("pwm low while count below duty");
    a_pwm_zero: assert property (!force_on && duty_act_reg == 8'h00 |=> !pwm_reg)
        else $error("pwm high with duty zero");
    a_pwm_full: assert property (enable && duty_act_reg == 8'hFF |=> pwm_reg)
        else $error("pwm low with full duty");
    a_out_invert: assert property (FAN_DRIVE_OUT == (pwm_reg ^ $past(invert)))
        else $error("fan output not pwm xor invert");
    a_src_select: assert property (cnt_tick |-> (prescale_reg[7] ? tick_slow : tick_fast))
        else $error("counter tick without selected source");
    a_div_bound: assert property (enable |-> div_reg <= prescale_reg[6:0])
        else $error("divider ran past prescale field");
    a_div_bypass: assert property (enable && prescale_reg[6:0] == 7'h00 && src_tick
                                   |-> cnt_tick)
        else $error("zero field did not pass source");
    a_ot_force: assert property (force_on |=> pwm_reg && FAN_DRIVE_OUT == !$past(invert))
        else $error("overtemperature did not force full duty");
    a_reset_vals: assert property (first_reg |-> prescale_reg == 8'h00 && duty_reg == 8'hFF)
        else $error("register reset values wrong");
    a_idle_hold: assert property (!enable && !force_on |=> count_reg == 8'h00 && !pwm_reg)
        else $error("disabled block not idle");
    a_duty_hold: assert property (enable && !(cnt_tick && count_reg == 8'hFF)
                                  |=> duty_act_reg == $past(duty_act_reg))
        else $error("duty changed mid cycle");

    c_wrap:   cover property (cnt_tick && count_reg == 8'hFF);
    c_force:  cover property (force_on && enable);
    c_duty:   cover property (wr_now && sel == fpwm_pkg::SEL_DUTY);
    c_invert: cover property (enable && invert && FAN_DRIVE_OUT);

endmodule

`default_nettype wire

// ---- verification/fpwm_fan_model.sv ----
// fan side model: measures high time and period of the fan drive in clocks
`timescale 1ns/100ps
`default_nettype none

module fpwm_fan_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // fan drive seen at the fan
    input  wire logic drive,
    // one measurement per rising edge of the drive after the first
    output var  logic meas_valid,
    output var  int   hi_cnt,
    output var  int   per_cnt
);
    int   hi_acc;
    int   per_acc;
    logic drive_d;
    logic seen;

    ////////////////////////////////////////////////////////////////////////////////
    // first edge only starts the count: a partial period is never reported
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_d <= 1'b0;
            seen <= 1'b0;
            meas_valid <= 1'b0;
            hi_acc <= 0;
            per_acc <= 0;
            hi_cnt <= 0;
            per_cnt <= 0;
        end else begin
            drive_d <= drive;
            meas_valid <= 1'b0;
            if (drive && !drive_d) begin
                meas_valid <= seen;
                hi_cnt <= hi_acc;
                per_cnt <= per_acc;
                seen <= 1'b1;
                hi_acc <= 1;
                per_acc <= 1;
            end else begin
                per_acc <= per_acc + 1;
                hi_acc <= hi_acc + (drive ? 1 : 0);
            end
        end
    end
endmodule

`default_nettype wire

// ---- verification/fpwm_top_bench.sv ----
// fan pwm bench: register access, duty and period on the fan, overtemperature force
`timescale 1ns/100ps
`default_nettype none
`include "fpwm_cfg.svh"

module fpwm_top_bench;
    logic        REF_CLK;
    logic        RESETN;
    logic [3:0]  AVS_ADDRESS;
    logic        AVS_READ;
    logic        AVS_WRITE;
    logic [31:0] AVS_WRITEDATA;
    logic [3:0]  AVS_BYTEENABLE;
    logic [31:0] AVS_READDATA;
    logic        AVS_WAITREQUEST;
    logic [1:0]  OVERTEMP_SHUTDOWN;
    logic        FAN_DRIVE_OUT;
    logic        meas_valid;
    int          hi_cnt;
    int          per_cnt;
    int          n_checks;
    int          miscompares;
    logic [31:0] rd_q[$];
    int          hi_q[$];
    int          per_q[$];
    logic [31:0] last_rd;
    logic [31:0] c0;
    logic [7:0]  d;
    int          seed;

    fpwm_top #(.OT_CH(2)) i_dut (
        .REF_CLK(REF_CLK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .OVERTEMP_SHUTDOWN(OVERTEMP_SHUTDOWN),
        .FAN_DRIVE_OUT(FAN_DRIVE_OUT));

    fpwm_fan_model i_fan (
        .clk(REF_CLK), .rst_n(RESETN), .drive(FAN_DRIVE_OUT),
        .meas_valid(meas_valid), .hi_cnt(hi_cnt), .per_cnt(per_cnt));

    always #2 REF_CLK = ~REF_CLK;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_near(input int got, input int exp, input int tol);
        n_checks++;
        if (got < exp - tol || got > exp + tol) begin
            miscompares++;
            $display("[ERR] %0t measured %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic ran_out;
        miscompares++;
        $display("[ERR] %0t wait ran out", $time);
        close_out();
    endtask

    // request held until waitrequest is seen low, released at that edge
    task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                            input logic [3:0] be);
        int n;
        n = 0;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= wd;
        AVS_BYTEENABLE <= be;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 40);
        if (!wr)
            last_rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        if (n >= 40)
            ran_out();
        @(posedge REF_CLK);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] wd);
        bus_xfer(1'b1, a, {24'h0, wd}, 4'hF);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus_xfer(1'b0, a, 32'h0, 4'hF);
    endtask

    task automatic hold_check(input logic level, input int n);
        int bad;
        bad = 0;
        repeat (n) begin
            @(negedge REF_CLK);
            if (FAN_DRIVE_OUT !== level)
                bad++;
        end
        @(posedge REF_CLK);
        cmp(32'(bad), 32'h0);
    endtask

    // program while disabled, then enable and queue the expected fan waveform
    task automatic measure(input logic [7:0] pre, input logic [7:0] dv, input logic inv);
        int per;
        int hi;
        int n;
        wr(`FPWM_OFS_CTRL, 8'h00);
        wr(`FPWM_OFS_PRESCALE, pre);
        wr(`FPWM_OFS_DUTY, dv);
        wr(`FPWM_OFS_CTRL, {6'h0, inv, 1'b1});
        per = ((int'(pre[6:0]) + 1) * 256 * 250) / 24;
        hi = per * (inv ? 256 - int'(dv) : int'(dv)) / 256;
        repeat (2 * per) @(posedge REF_CLK);
        hi_q.push_back(hi);
        per_q.push_back(per);
        n = 0;
        while (hi_q.size() > 0 && n < 3 * per) begin
            @(posedge REF_CLK);
            n++;
        end
        if (hi_q.size() > 0)
            ran_out();
        rd(`FPWM_OFS_PRESCALE, {24'h0, pre});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // result watcher: read data and fan measurements against the oldest note
    always @(negedge REF_CLK) begin
        if (AVS_READ && AVS_WAITREQUEST === 1'b0) begin
            if (rd_q.size() > 0)
                cmp(AVS_READDATA, rd_q.pop_front());
        end
        if (meas_valid && hi_q.size() > 0) begin
            cmp_near(hi_cnt, hi_q.pop_front(), 16);
            cmp_near(per_cnt, per_q.pop_front(), 16);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        REF_CLK = 1'b0;
        RESETN = 1'b0;
        AVS_ADDRESS = 4'h0;
        AVS_READ = 1'b0;
        AVS_WRITE = 1'b0;
        AVS_WRITEDATA = 32'h0;
        AVS_BYTEENABLE = 4'h0;
        OVERTEMP_SHUTDOWN = 2'h0;
        n_checks = 0;
        miscompares = 0;
        seed = $urandom(32'hBD8E5CE1);
        repeat (12) @(posedge REF_CLK);
        RESETN <= 1'b1;
        @(posedge REF_CLK);
        rd(`FPWM_OFS_PRESCALE, 32'h0);
        rd(`FPWM_OFS_DUTY, 32'hFF);
        rd(`FPWM_OFS_CTRL, 32'h0);
        rd(`FPWM_OFS_STATUS, 32'h0);
        rd(4'h2, 32'h0);
        bus_xfer(1'b1, `FPWM_OFS_PRESCALE, 32'h85, 4'h0);
        wr(4'h6, 8'h55);
        rd(`FPWM_OFS_PRESCALE, 32'h0);
        rd(4'h6, 32'h0);
        // duty extremes: no pulse at either end
        wr(`FPWM_OFS_DUTY, 8'h00);
        wr(`FPWM_OFS_CTRL, 8'h01);
        repeat (3000) @(posedge REF_CLK);
        hold_check(1'b0, 3000);
        wr(`FPWM_OFS_DUTY, 8'hFF);
        repeat (3000) @(posedge REF_CLK);
        hold_check(1'b1, 3000);
        for (int k = 0; k < 2; k++) begin
            d = 8'($urandom_range(16, 239));
            measure(k ? 8'h01 : 8'h00, d, k[0]);
        end
        wr(`FPWM_OFS_CTRL, 8'h00);
        repeat (4) @(posedge REF_CLK);
        rd(`FPWM_OFS_STATUS, 32'h0);
        // slow source: one counter step per 1250 clocks
        wr(`FPWM_OFS_PRESCALE, 8'h80);
        wr(`FPWM_OFS_CTRL, 8'h01);
        bus_xfer(1'b0, `FPWM_OFS_STATUS, 32'h0, 4'hF);
        c0 = last_rd;
        repeat (5000) @(posedge REF_CLK);
        bus_xfer(1'b0, `FPWM_OFS_STATUS, 32'h0, 4'hF);
        cmp_near(int'(8'(last_rd[7:0] - c0[7:0])), 4, 1);
        // overtemperature: ignored without the force bit, full drive with it
        wr(`FPWM_OFS_CTRL, 8'h00);
        wr(`FPWM_OFS_DUTY, 8'h00);
        OVERTEMP_SHUTDOWN <= 2'b10;
        repeat (8) @(posedge REF_CLK);
        hold_check(1'b0, 50);
        wr(`FPWM_OFS_CTRL, 8'h04);
        repeat (4) @(posedge REF_CLK);
        hold_check(1'b1, 50);
        rd(`FPWM_OFS_STATUS, 32'h0000_0700);
        OVERTEMP_SHUTDOWN <= 2'b00;
        repeat (6) @(posedge REF_CLK);
        hold_check(1'b0, 20);
        close_out();
    end
endmodule

`default_nettype wire
